/* design/peak_adc_ctrl.sv */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "peak_adc_map.svh"
module peak_adc_ctrl #(
	parameter int CLK_PERIOD_NS = `CLK_PERIOD_NS
) (
	input wire logic clk, // 10 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error
	input wire logic gate_in, // front-panel gate
	input wire logic clear_in, // front-panel clear
	input wire logic ecl_ack, // ECL reader takes a word on rise
	input wire logic [7:0] chan_hit, // per-channel above-threshold flags
	input wire logic [11:0] conv_value, // converter result
	output logic [7:0] thresh_level, // common threshold level
	output logic [7:0] offset_level, // offset of selected channel
	output logic [2:0] mux_sel, // analog multiplexer channel
	output logic conv_start, // one-cycle start of a conversion
	output logic test_pulse, // test pulse into all channels
	output logic busy, // acquisition busy
	output logic lam, // look-at-me
	output logic ecl_req, // ECL word ready
	output logic [15:0] ecl_data // ECL data word
);
	localparam int GATE_CYC = (`GATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CYC = (`CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_CYC = (`CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// first index at or above f whose mask bit is set, 8 if none
	function automatic logic [3:0] next_idx(input logic [7:0] m, input logic [3:0] f);
		logic [3:0] r;
		r = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			if (m[i] && 4'(i) >= f) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	peak_adc_pkg::pin_in_t pins_a_q, pins_b_q;
	logic gate_prev_q, clear_prev_q, ack_prev_q;
	peak_adc_pkg::state_t state_q;
	peak_adc_pkg::phase_t phase_q;
	peak_adc_pkg::mode_t mode_q;
	logic [7:0] thresh_q;
	peak_adc_pkg::chan_param_t param_q [8];
	peak_adc_pkg::data_word_t word_q [8];
	logic [7:0] valid_q;
	logic [5:0] cnt_q;
	logic [5:0] clr_cnt_q;
	logic [2:0] ch_q;
	logic [3:0] ptr_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rdata_d;
	logic err_d;
	logic [7:0] offset_q;
	logic conv_start_q, test_q, lam_q, ecl_req_q;
	logic [15:0] ecl_data_q;

	// two flip-flops on every panel, ECL and converter pin before any logic looks at it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_a_q <= '0;
			pins_b_q <= '0;
			gate_prev_q <= 1'b0;
			clear_prev_q <= 1'b0;
			ack_prev_q <= 1'b0;
		end else begin
			pins_a_q <= {gate_in, clear_in, ecl_ack, chan_hit, conv_value};
			pins_b_q <= pins_a_q;
			gate_prev_q <= pins_b_q.gate;
			clear_prev_q <= pins_b_q.clear;
			ack_prev_q <= pins_b_q.ack;
		end
	end

	logic apb_wr, apb_rd, idle, reading;
	logic sw_gate, sw_clear, sw_test, sw_init;
	logic gate_evt, clear_evt, int_clear, gate_ok;
	logic zs_mode, ecl_mode, seq_have, seq_pop;
	logic conv_end, conv_last, cur_valid, cur_ovf;
	logic [7:0] avail, valid_next;
	logic [2:0] rch;
	peak_adc_pkg::chan_param_t cur_par;

	assign apb_wr = psel && penable && pready_q && pwrite;
	assign apb_rd = psel && penable && pready_q && !pwrite;
	assign idle = state_q == peak_adc_pkg::S_IDLE;
	assign reading = phase_q == peak_adc_pkg::P_READ;
	assign rch = paddr[4:2];
	assign sw_gate = apb_wr && paddr == `OFF_CTRL && pwdata[`CTRL_GATE];
	assign sw_clear = apb_wr && paddr == `OFF_CTRL && pwdata[`CTRL_CLEAR];
	assign sw_test = apb_wr && paddr == `OFF_CTRL && pwdata[`CTRL_TEST];
	assign sw_init = apb_wr && paddr == `OFF_CTRL && pwdata[`CTRL_INIT];
	// panel and bus sources merge here, so both behave the same
	assign gate_evt = (pins_b_q.gate && !gate_prev_q) || sw_gate || sw_test;
	assign clear_evt = (pins_b_q.clear && !clear_prev_q) || sw_clear || sw_init;
	assign gate_ok = idle && clr_cnt_q == 6'h00;
	assign zs_mode = mode_q.seq_en && mode_q.zs_en;
	assign ecl_mode = mode_q.ecl_readout_select && mode_q.seq_en;
	assign avail = zs_mode ? valid_q : 8'hff;
	assign cur_par = param_q[ch_q];
	assign cur_ovf = pins_b_q.conv >= `OVF_LIMIT;
	assign cur_valid = pins_b_q.hit[ch_q] && pins_b_q.conv[11:4] >= cur_par.lower_window_limit
		&& pins_b_q.conv[11:4] <= cur_par.upper_window_limit;
	assign conv_end = phase_q == peak_adc_pkg::P_CONV && cnt_q == 6'h00;
	assign conv_last = conv_end && ch_q == 3'h7;
	assign valid_next = valid_q | (cur_valid ? 8'h01 << ch_q : 8'h00);
	assign seq_have = reading && mode_q.seq_en && !ptr_q[3];
	assign seq_pop = seq_have && (ecl_mode ? (pins_b_q.ack && !ack_prev_q && ecl_req_q)
		: (apb_rd && paddr == `OFF_DATA));
	// nothing to read after conversion, or sequential list drained
	assign int_clear = (conv_last && (zs_mode ? valid_next : 8'hff) == 8'h00)
		|| (reading && mode_q.seq_en && ptr_q[3]);

	// two-state controller with its busy sub-phases
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= peak_adc_pkg::S_IDLE;
			phase_q <= peak_adc_pkg::P_NONE;
			cnt_q <= 6'h00;
			ch_q <= 3'h0;
			clr_cnt_q <= 6'h00;
			test_q <= 1'b0;
		end else if (clear_evt || int_clear) begin
			state_q <= peak_adc_pkg::S_IDLE;
			phase_q <= peak_adc_pkg::P_NONE;
			clr_cnt_q <= 6'(CLEAR_CYC);
			test_q <= 1'b0;
		end else begin
			if (clr_cnt_q != 6'h00) begin
				clr_cnt_q <= clr_cnt_q - 6'h01;
			end
			unique case (state_q)
				peak_adc_pkg::S_IDLE: begin
					if (gate_evt && gate_ok) begin
						state_q <= peak_adc_pkg::S_BUSY;
						phase_q <= peak_adc_pkg::P_DELAY;
						cnt_q <= 6'(GATE_CYC - 1);
						test_q <= sw_test;
					end
				end
				peak_adc_pkg::S_BUSY: begin
					unique case (phase_q)
						peak_adc_pkg::P_DELAY: begin
							if (cnt_q == 6'h00) begin
								phase_q <= peak_adc_pkg::P_CONV;
								ch_q <= 3'h0;
								cnt_q <= 6'(CONV_CYC - 1);
								test_q <= 1'b0;
							end else begin
								cnt_q <= cnt_q - 6'h01;
							end
						end
						peak_adc_pkg::P_CONV: begin
							if (conv_last) begin
								phase_q <= peak_adc_pkg::P_READ;
							end else if (conv_end) begin
								ch_q <= ch_q + 3'h1;
								cnt_q <= 6'(CONV_CYC - 1);
							end else begin
								cnt_q <= cnt_q - 6'h01;
							end
						end
						default: begin
						end
					endcase
				end
			endcase
		end
	end

	// results captured per channel at the end of each conversion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				word_q[i] <= '0;
			end
		end else if (clear_evt || (idle && gate_evt && gate_ok)) begin
			valid_q <= 8'h00;
		end else if (conv_end) begin
			valid_q <= valid_next;
			word_q[ch_q].value <= pins_b_q.conv;
			word_q[ch_q].chan <= mode_q.chan_tag_mask ? 3'h0 : ch_q;
			word_q[ch_q].ovf <= cur_ovf && !mode_q.ovf_mask;
		end
	end

	// sequential pointer, advanced by ECL ack or dataway read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= 4'h8;
		end else if (conv_last) begin
			ptr_q <= next_idx(zs_mode ? valid_next : 8'hff, 4'h0);
		end else if (seq_pop) begin
			ptr_q <= next_idx(avail, ptr_q + 4'h1);
		end
	end

	// configuration; writes while busy are dropped and flagged
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= `MODE_RESET;
			thresh_q <= `THRESH_RESET;
			for (int i = 0; i < 8; i++) begin
				param_q[i] <= `PARAM_RESET;
			end
		end else if (sw_init) begin
			mode_q <= `MODE_RESET;
		end else if (apb_wr && idle) begin
			if (paddr == `OFF_MODE) begin
				mode_q <= pwdata[5:0];
			end
			if (paddr == `OFF_THRESH) begin
				thresh_q <= pwdata[7:0];
			end
			if (paddr[7:5] == `WIN_PARAM && paddr[1:0] == 2'b00) begin
				param_q[rch] <= pwdata[23:0];
			end
		end
	end

	// read data and error decided in the setup cycle
	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			err_d = 1'b1;
		end else if (paddr == `OFF_CTRL) begin
			rdata_d = 32'h0000_0000;
		end else if (paddr == `OFF_MODE) begin
			rdata_d = {26'h0, mode_q};
			err_d = pwrite && !idle;
		end else if (paddr == `OFF_THRESH) begin
			rdata_d = {24'h0, thresh_q};
			err_d = pwrite && !idle;
		end else if (paddr == `OFF_STATUS) begin
			rdata_d = {16'h0, valid_q, 3'h0, ecl_req_q, lam_q, clr_cnt_q != 6'h00, reading, !idle};
		end else if (paddr == `OFF_DATA) begin
			// Q in bit 16; a Q of zero ends a sequential block read
			if (seq_have && !ecl_mode) begin
				rdata_d = {15'h0, 1'b1, word_q[ptr_q[2:0]]};
			end
			err_d = pwrite;
		end else if (paddr[7:5] == `WIN_CHAN) begin
			if (reading && !mode_q.seq_en) begin
				rdata_d = {15'h0, 1'b1, word_q[rch]};
			end
			err_d = pwrite;
		end else if (paddr[7:5] == `WIN_PARAM) begin
			rdata_d = {8'h0, param_q[rch]};
			err_d = pwrite && !idle;
		end else begin
			err_d = 1'b1;
		end
	end

	// one wait-free access phase: ready is registered off the setup cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && !penable;
			if (psel && !penable) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
				pslverr_q <= err_d;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// port outputs; ECL word held until the reader acknowledges it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			offset_q <= 8'h00;
			conv_start_q <= 1'b0;
			lam_q <= 1'b0;
			ecl_req_q <= 1'b0;
			ecl_data_q <= 16'h0000;
		end else begin
			offset_q <= param_q[ch_q].offset;
			conv_start_q <= (phase_q == peak_adc_pkg::P_DELAY && cnt_q == 6'h00)
				|| (conv_end && !conv_last);
			lam_q <= mode_q.lam_en && !ecl_mode && reading
				&& (mode_q.seq_en ? seq_have : 1'b1) && !clear_evt;
			ecl_req_q <= ecl_mode && seq_have && !seq_pop && !clear_evt;
			if (seq_have && ecl_mode) begin
				ecl_data_q <= word_q[ptr_q[2:0]];
			end
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign thresh_level = thresh_q;
	assign offset_level = offset_q;
	assign mux_sel = ch_q;
	assign conv_start = conv_start_q;
	assign test_pulse = test_q;
	// one-hot code: the busy bit is the state flop itself
	assign busy = state_q[1];
	assign lam = lam_q;
	assign ecl_req = ecl_req_q;
	assign ecl_data = ecl_data_q;
endmodule

/* design/peak_adc_map.svh */
`ifndef PEAK_ADC_MAP_SVH
`define PEAK_ADC_MAP_SVH
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_MODE 8'h04
`define OFF_THRESH 8'h08
`define OFF_STATUS 8'h0c
`define OFF_DATA 8'h10
// windows selected by paddr[7:5]; paddr[4:2] is the channel
`define WIN_CHAN 3'h1
`define WIN_PARAM 3'h2
// command bits in the control register
`define CTRL_GATE 0
`define CTRL_CLEAR 1
`define CTRL_TEST 2
`define CTRL_INIT 3
// reset values
`define MODE_RESET 6'h3f
`define THRESH_RESET 8'h00
`define PARAM_RESET 24'h00ff00
// conversion codes at or above this limit are overflow
`define OVF_LIMIT 12'hf00
// timing in ns
`define CLK_PERIOD_NS 100
`define GATE_DELAY_NS 1000
`define CONV_TIME_NS 3000
`define CLEAR_TIME_NS 1200
`endif

/* design/peak_adc_pkg.sv */
package peak_adc_pkg;
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_BUSY = 2'b10
	} state_t;
	typedef enum logic [3:0] {
		P_NONE = 4'b0001,
		P_DELAY = 4'b0010,
		P_CONV = 4'b0100,
		P_READ = 4'b1000
	} phase_t;
	typedef struct packed {
		logic lam_en;
		logic seq_en;
		logic zs_en;
		logic ovf_mask;
		logic ecl_readout_select;
		logic chan_tag_mask;
	} mode_t;
	typedef struct packed {
		logic ovf;
		logic [2:0] chan;
		logic [11:0] value;
	} data_word_t;
	typedef struct packed {
		logic [7:0] offset;
		logic [7:0] upper_window_limit;
		logic [7:0] lower_window_limit;
	} chan_param_t;
	typedef struct packed {
		logic gate;
		logic clear;
		logic ack;
		logic [7:0] hit;
		logic [11:0] conv;
	} pin_in_t;
endpackage

/* tb/ecl_reader_model.sv */
`timescale 1ns/10ps
module ecl_reader_model (
	input wire logic clk, // system clock
	input wire logic ecl_req, // word offered
	input wire logic [15:0] ecl_data, // offered word
	input wire logic [3:0] lag, // cycles of hesitation before a take
	output logic ecl_ack, // take strobe
	output logic [7:0] n_words // words taken so far
);
	logic [15:0] words [0:7];
	initial begin
		ecl_ack = 1'b0;
		n_words = 8'h00;
		forever begin
			@(posedge clk);
			if (ecl_req === 1'b1) begin
				repeat (lag) @(posedge clk);
				words[n_words[2:0]] = ecl_data;
				n_words = n_words + 8'h01;
				ecl_ack <= 1'b1;
				repeat (3) @(posedge clk);
				ecl_ack <= 1'b0;
				// do not take the same word twice: wait up to 4 cycles for the request to drop
				for (int k = 0; k < 4 && ecl_req === 1'b1; k++) @(posedge clk);
			end
		end
	end
endmodule

/* tb/peak_adc_ctrl_sva.sv */
`timescale 1ns/10ps
module peak_adc_ctrl_sva (
	input wire logic clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb address
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic clear_in, // panel clear
	input wire logic ecl_ack, // ecl take
	input wire logic conv_start, // conversion start
	input wire logic test_pulse, // test pulse
	input wire logic busy, // busy
	input wire logic lam, // look-at-me
	input wire logic ecl_req, // ecl word ready
	input wire logic [15:0] ecl_data // ecl word
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] gap_q;
	logic seen_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 8'h00;
		end else if (conv_start) begin
			gap_q <= 8'h01;
		end else if (gap_q != 8'hff) begin
			gap_q <= gap_q + 8'h01;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= busy && (seen_q || conv_start);
		end
	end
	sequence s_quiet;
		!conv_start[*8];
	endsequence
	sequence s_take;
		ecl_req && $rose(ecl_ack);
	endsequence
	property p_answer;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	property p_refuse;
		pready && pwrite && busy && $past(busy) && (paddr inside {8'h04, 8'h08} || paddr[7:5] == 3'h2) |-> pslverr;
	endproperty
	property p_first_conv;
		$rose(busy) |-> s_quiet ##[1:12] conv_start;
	endproperty
	property p_conv_gap;
		conv_start && seen_q |-> gap_q >= 8'h19 && gap_q <= 8'h23;
	endproperty
	property p_test;
		$fell(test_pulse) |-> busy;
	endproperty
	property p_ecl_hold;
		ecl_req && $past(ecl_req) |-> $stable(ecl_data);
	endproperty
	property p_ecl_pop;
		s_take |-> ##[1:4] !ecl_req;
	endproperty
	property p_offer_busy;
		ecl_req || lam |-> busy;
	endproperty
	property p_clear;
		$rose(clear_in) |-> ##5 !busy[*8];
	endproperty
	a_answer: assert property (p_answer) else $error("no single access cycle");
	a_refuse: assert property (p_refuse) else $error("write while busy accepted");
	a_first_conv: assert property (p_first_conv) else $error("conversion start misplaced");
	a_conv_gap: assert property (p_conv_gap) else $error("conversion spacing wrong");
	a_test: assert property (p_test) else $error("test pulse without busy");
	a_ecl_hold: assert property (p_ecl_hold) else $error("ecl word moved while offered");
	a_ecl_pop: assert property (p_ecl_pop) else $error("ecl request kept after take");
	a_offer_busy: assert property (p_offer_busy) else $error("data offered while idle");
	a_clear: assert property (p_clear) else $error("busy during clear recovery");
endmodule
bind peak_adc_ctrl peak_adc_ctrl_sva i_sva (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.clear_in, .ecl_ack, .conv_start, .test_pulse, .busy, .lam, .ecl_req, .ecl_data);

/* tb/test_peak_adc_acquire_readout_control.sv */
`timescale 1ns/10ps
module test_peak_adc_acquire_readout_control;
	typedef struct packed {
		logic [5:0] mode;
		logic [7:0] hits;
		logic [11:0] conv;
		logic [3:0] lag;
		logic [3:0] n;
	} row_t;
	row_t rows [0:5] = '{'{6'h18, 8'h05, 12'h123, 4'h0, 4'h2}, '{6'h30, 8'h00, 12'hf10, 4'h0, 4'h8},
		'{6'h15, 8'hff, 12'hf80, 4'h0, 4'h8}, '{6'h3a, 8'h81, 12'h456, 4'h0, 4'h2},
		'{6'h1a, 8'hff, 12'hfff, 4'h6, 4'h7}, '{6'h38, 8'h40, 12'h123, 4'h0, 4'h0}};
	row_t row;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gate_in = 1'b0, clear_in = 1'b0, apb_err;
	logic [7:0] paddr = 8'h00, chan_hit = 8'h00, base, thresh_level, offset_level, n_words;
	logic [31:0] pwdata = 32'h0, apb_rd, prdata;
	logic [11:0] conv_value = 12'h000;
	logic [3:0] lag = 4'h0;
	logic pready, pslverr, ecl_ack, conv_start, test_pulse, busy, lam, ecl_req;
	logic [2:0] mux_sel;
	logic [15:0] ecl_data;
	int miscompares = 0, n_checks = 0, i;
	always #50 clk = ~clk;
	peak_adc_ctrl i_peak_adc_ctrl (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .gate_in, .clear_in, .ecl_ack, .chan_hit, .conv_value, .thresh_level, .offset_level, .mux_sel,
		.conv_start, .test_pulse, .busy, .lam, .ecl_req, .ecl_data);
	ecl_reader_model i_ecl_reader_model (.clk, .ecl_req, .ecl_data, .lag, .ecl_ack, .n_words);
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic hang;
		miscompares++;
		$display("unexpected at %0t: wait ran out", $time);
		end_sim();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) hang();
		apb_rd = prdata;
		apb_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int k;
		for (k = 0; k < 300; k++) begin
			apb(1'b0, 8'h0c, 32'h0);
			if ((apb_rd & m) === v) break;
		end
		if (k == 300) hang();
	endtask
	task automatic pin(input logic g);
		gate_in <= g;
		clear_in <= !g;
		repeat (4) @(posedge clk);
		gate_in <= 1'b0;
		clear_in <= 1'b0;
	endtask
	// expected dataway word of channel c, with Q in bit 16
	function automatic logic [31:0] word_of(input row_t r, input int c);
		peak_adc_pkg::data_word_t w;
		w.value = r.conv;
		w.chan = r.mode[0] ? 3'h0 : c[2:0];
		w.ovf = !r.mode[2] && r.conv >= 12'hf00;
		return {15'h0, 1'b1, w};
	endfunction
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk(apb_rd, 32'h3f);
		apb(1'b0, 8'h48, 32'h0);
		chk(apb_rd, 32'h00ff00);
		apb(1'b0, 8'hfc, 32'h0);
		chk({apb_rd[30:0], apb_err}, 32'h1);
		apb(1'b0, 8'h0a, 32'h0);
		chk({apb_rd[30:0], apb_err}, 32'h1);
		apb(1'b1, 8'h08, 32'ha5);
		apb(1'b0, 8'h08, 32'h0);
		chk({apb_rd[23:0], thresh_level}, 32'ha5a5);
		// window of channel 6 rejects every row value
		apb(1'b1, 8'h58, 32'h336050);
		for (int r = 0; r < 6; r++) begin
			row = rows[r];
			apb(1'b1, 8'h04, {26'h0, row.mode});
			chan_hit <= row.hits;
			conv_value <= row.conv;
			lag <= row.lag;
			base = n_words;
			pin(1'b1);
			if (row.n != 4'h0 && row.mode[1]) begin
				for (i = 0; i < 900 && n_words - base != {4'h0, row.n}; i++) @(posedge clk);
				if (i == 900) hang();
			end else if (row.n != 4'h0) begin
				poll(32'h2, 32'h2);
				chk({30'h0, lam, ecl_req}, {30'h0, row.mode[5], 1'b0});
			end
			i = 0;
			for (int c = 0; c < 8; c++) begin
				if (!row.mode[3] || (row.hits[c] && (c != 6 || row.conv[11:4] inside {[8'h50:8'h60]}))) begin
					if (row.mode[1]) begin
						chk({16'h1, i_ecl_reader_model.words[base[2:0] + i[2:0]]}, word_of(row, c));
					end else begin
						apb(1'b0, 8'h10, 32'h0);
						chk(apb_rd, word_of(row, c));
					end
					i++;
				end
			end
			poll(32'h1, 32'h0);
			apb(1'b0, 8'h10, 32'h0);
			chk(apb_rd, 32'h0);
			poll(32'h4, 32'h0);
		end
		row = '{6'h00, 8'h0f, 12'hf55, 4'h0, 4'h0};
		apb(1'b1, 8'h04, 32'h0);
		chan_hit <= row.hits;
		conv_value <= row.conv;
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h04, 32'h3f);
		chk({apb_rd[30:0], apb_err}, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk(apb_rd, 32'h0);
		pin(1'b1);
		// channel 6 is the only one with a non-zero offset
		for (i = 0; i < 400 && mux_sel !== 3'h6; i++) @(posedge clk);
		if (i == 400) hang();
		@(posedge clk);
		@(posedge clk);
		chk({21'h0, mux_sel, offset_level}, {21'h0, 3'h6, 8'h33});
		poll(32'h2, 32'h2);
		apb(1'b0, 8'h34, 32'h0);
		chk(apb_rd, word_of(row, 5));
		apb(1'b0, 8'h28, 32'h0);
		chk(apb_rd, word_of(row, 2));
		chk({31'h0, busy}, 32'h1);
		apb(1'b1, 8'h00, 32'h2);
		poll(32'h1, 32'h0);
		pin(1'b0);
		// let one edge pass so the gate and clear pins are not driven twice at once
		@(posedge clk);
		pin(1'b1);
		repeat (20) @(posedge clk);
		chk({31'h0, busy}, 32'h0);
		apb(1'b1, 8'h00, 32'h8);
		apb(1'b0, 8'h04, 32'h0);
		chk(apb_rd, 32'h3f);
		chan_hit <= 8'h00;
		poll(32'h4, 32'h0);
		apb(1'b1, 8'h00, 32'h4);
		repeat (3) @(posedge clk);
		chk({30'h0, test_pulse, busy}, 32'h3);
		poll(32'h1, 32'h0);
		end_sim();
	end
endmodule
